// [dv/sdcs_host.sv]
// Host model of the serial link: frames words and reads status back
`timescale 1ns/100ps
`default_nettype none
module sdcs_host (
  // Clock
  input wire logic ref_clk,
  // Link
  output logic chip_select_n,
  output logic shift_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic last_q = 1'b0;
  logic sdo_line;
  // A released line toggles so a stale bit never reads as good
  assign sdo_line = serial_out_oe ? serial_out : ~last_q;
  always @(posedge ref_clk) last_q <= sdo_line;
  initial
  begin
    chip_select_n = 1'b1;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic xfer(input logic [15:0] c, input int n, output logic [15:0] s);
    s = '0;
    @(posedge ref_clk) chip_select_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      shift_clock <= 1'b1;
      serial_in <= c[i];
      repeat (4) @(posedge ref_clk);
      shift_clock <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) s[i] = sdo_line;
      @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    chip_select_n <= 1'b1;
    serial_in <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [dv/sdcs_top_properties.sv]
// Port-level concurrent checks of the serial driver control block
`timescale 1ns/100ps
`default_nettype none
module sdcs_props #(
  parameter int SHORT_LONG_CYC = 2500000,
  parameter int OV_LONG_CYC = 375000,
  parameter int UV_CYC = 250000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Watched ports
  input wire logic chip_select_n,
  input wire logic shift_clock,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic standby_pin_n,
  input wire logic supply_over,
  input wire logic supply_under,
  input wire logic temp_shutdown,
  input wire logic [11:0] short_detect,
  input wire logic [11:0] switch_on,
  input wire logic standby_state
);
  localparam int SUP_MAX = (OV_LONG_CYC > UV_CYC) ? OV_LONG_CYC : UV_CYC;
  int short_cnt_q;
  int sup_cnt_q;
  // Limits carry slack for the input synchronisers
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) short_cnt_q <= 0;
    else short_cnt_q <= |(short_detect & switch_on) ? short_cnt_q + 1 : 0;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) sup_cnt_q <= 0;
    else sup_cnt_q <= (supply_over || supply_under) ? sup_cnt_q + 1 : 0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  oe_idle_a: assert property (chip_select_n [*5] |-> !serial_out_oe)
    else $error("serial_out driven while deselected");
  oe_drive_a: assert property (!chip_select_n [*6] |-> serial_out_oe)
    else $error("serial_out not driven in frame");
  // A change inside a frame must trail a recent shift_clock rise, never a fall
  sdo_stable_a: assert property (
    !chip_select_n [*7] ##0 $changed(serial_out) |-> $past(shift_clock, 3))
    else $error("serial_out moved without a clock rise");
  output_hold_a: assert property (!chip_select_n [*8] |-> $stable(switch_on))
    else $error("outputs changed inside a frame");
  standby_off_a: assert property (!standby_pin_n [*5] |-> standby_state && switch_on == '0)
    else $error("outputs on during standby");
  supply_cut_a: assert property (sup_cnt_q > SUP_MAX + 8 |-> switch_on == '0)
    else $error("outputs on after supply delay");
  short_cut_a: assert property (short_cnt_q < SHORT_LONG_CYC + 8)
    else $error("shorted output left on too long");
  thermal_off_a: assert property (temp_shutdown [*5] |-> switch_on == '0)
    else $error("outputs on in thermal shutdown");
endmodule
bind sdcs_top sdcs_props #(.SHORT_LONG_CYC(SHORT_LONG_CYC), .OV_LONG_CYC(OV_LONG_CYC), .UV_CYC(UV_CYC))
  u_props (.ref_clk, .reset_n, .chip_select_n, .shift_clock, .serial_out, .serial_out_oe, .standby_pin_n,
  .supply_over, .supply_under, .temp_shutdown, .short_detect, .switch_on, .standby_state);
`default_nettype wire

// [dv/sdcs_top_tb.sv]
// Self-checking bench of the serial driver control block
`timescale 1ns/100ps
`default_nettype none
module sdcs_top_tb;
  localparam int SL = 40;
  localparam int SS = 10;
  localparam int OL = 20;
  localparam int OS = 8;
  localparam int UV = 15;
  logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, standby_pin_n = 1'b1, supply_over = 1'b0, supply_under = 1'b0;
  logic temp_warn_set = 1'b0, temp_warn_reset = 1'b0, temp_shutdown = 1'b0;
  logic [11:0] short_detect = '0, open_load_detect = '0, switch_on, open_load_current_en;
  logic chip_select_n, shift_clock, serial_in, serial_out, serial_out_oe, standby_state;
  logic [15:0] st, c, prev;
  logic [31:0] seed = 32'h0177_808b;
  int n_errors = 0;
  int n_compared = 0;
  sdcs_top #(.SHORT_LONG_CYC(SL), .SHORT_SHORT_CYC(SS), .OV_LONG_CYC(OL), .OV_SHORT_CYC(OS), .UV_CYC(UV))
  u_dut (.ref_clk, .reset_n, .clk_en, .chip_select_n, .shift_clock, .serial_in, .serial_out,
    .serial_out_oe, .standby_pin_n, .supply_over, .supply_under, .temp_warn_set, .temp_warn_reset,
    .temp_shutdown, .short_detect, .open_load_detect, .switch_on, .open_load_current_en, .standby_state);
  sdcs_host u_host (.ref_clk, .chip_select_n, .shift_clock, .serial_in, .serial_out, .serial_out_oe);
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_st(input logic [15:0] k, input logic [11:0] sw, input logic f, b, h, w);
    return {f, b, h, k[13] ? sw : open_load_detect & ~k[12:1], w};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Kinds: 0 short, 1 overvoltage, 2 undervoltage, 3 short with warning set
  task automatic fault(input int k, input logic short_delay_select);
    int d;
    logic sup;
    d = (k == 1) ? (short_delay_select ? OL : OS) : (k == 2) ? UV : (k == 3) ? 0 : (short_delay_select ? SL : SS);
    sup = (k == 1) || (k == 2);
    c = {1'b1, short_delay_select, 1'b1, 12'h001, 1'b0};
    if (k == 3) @(posedge ref_clk) temp_warn_set <= 1'b1;
    u_host.xfer(c, 16, st);
    @(posedge ref_clk)
    begin
      supply_over <= (k == 1);
      supply_under <= (k == 2);
      short_detect <= {11'h0, !sup};
    end
    if (d > 2) wt(d - 2);
    if (d > 2) chk("sw_early", 1, switch_on);
    wt(14);
    chk("sw_cut", 0, switch_on);
    @(posedge ref_clk)
    begin
      supply_over <= 1'b0;
      supply_under <= 1'b0;
      short_detect <= '0;
      temp_warn_set <= 1'b0;
      temp_warn_reset <= 1'b1;
    end
    wt(6);
    chk("sw_back", sup, switch_on);
    u_host.xfer(c, 16, st);
    chk("status", exp_st(c, {11'h0, sup}, sup, 0, !sup, 0), st);
    u_host.xfer(c | 16'h0001, 16, st);
    wt(2);
    chk("sw_clear", 1, switch_on);
    u_host.xfer(c, 16, st);
    chk("status", exp_st(c, 12'h001, 0, 0, 0, 0), st);
    @(posedge ref_clk) temp_warn_reset <= 1'b0;
  endtask
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    wt(8);
    chk("sw", 0, switch_on);
    chk("ol_en", 0, open_load_current_en);
    u_host.xfer(16'he000, 16, st);
    chk("status", 0, st);
    $display("test reset done");
    prev = 16'he000;
    for (int i = 0; i < 8; i++)
    begin
      c = 16'((rnd() & 32'h0000_5ffe) | 32'h0000_a000);
      if (i == 0) c = 16'hfffe;
      u_host.xfer(c, 16, st);
      chk("status", exp_st(prev, prev[12:1], 0, 0, 0, 0), st);
      wt(2);
      chk("sw", c[12:1], switch_on);
      prev = c;
    end
    @(posedge ref_clk) temp_warn_set <= 1'b1;
    wt(6);
    u_host.xfer(16'hffff, 1, st);
    chk("warn", 1, st[0]);
    chk("sw", prev[12:1], switch_on);
    @(posedge ref_clk) temp_warn_set <= 1'b0;
    @(posedge ref_clk) temp_warn_reset <= 1'b1;
    wt(6);
    u_host.xfer(16'hffff, 1, st);
    chk("warn", 0, st[0]);
    @(posedge ref_clk) temp_warn_reset <= 1'b0;
    // A frozen block must not see a condition that comes and goes meanwhile
    @(posedge ref_clk)
    begin
      clk_en <= 1'b0;
      temp_warn_set <= 1'b1;
    end
    wt(6);
    @(posedge ref_clk) temp_warn_set <= 1'b0;
    @(posedge ref_clk) clk_en <= 1'b1;
    wt(4);
    u_host.xfer(16'hffff, 1, st);
    chk("freeze", 0, st[0]);
    $display("test frames done");
    @(posedge ref_clk) open_load_detect <= 12'h003;
    u_host.xfer(16'hc002, 16, st);
    wt(2);
    chk("ol_en", 12'hffe, open_load_current_en);
    u_host.xfer(16'he002, 16, st);
    chk("status", exp_st(16'hc002, 0, 0, 0, 0, 0), st);
    wt(2);
    chk("ol_en", 0, open_load_current_en);
    $display("test open load done");
    @(posedge ref_clk) temp_shutdown <= 1'b1;
    wt(6);
    chk("sw", 0, switch_on);
    u_host.xfer(16'he002, 16, st);
    chk("status", 16'hffff, st);
    @(posedge ref_clk) temp_shutdown <= 1'b0;
    wt(6);
    chk("sw", 0, switch_on);
    u_host.xfer(16'he003, 16, st);
    wt(2);
    chk("sw", 1, switch_on);
    $display("test thermal done");
    for (int s = 0; s < 2; s++)
    begin
      if (s == 1) @(posedge ref_clk) standby_pin_n <= 1'b0;
      else u_host.xfer(16'h6002, 16, st);
      wt(6);
      chk("standby", 1, standby_state);
      chk("sw", 0, switch_on);
      u_host.xfer(16'he002, 16, st);
      chk("status", exp_st(16'he002, 0, 0, 1, 0, 0), st);
      @(posedge ref_clk) standby_pin_n <= 1'b1;
      wt(6);
      chk("sw", 1, switch_on);
    end
    $display("test standby done");
    for (int k = 0; k < 8; k++) fault(k / 2, k[0]);
    $display("test faults done");
    complete_run();
  end
endmodule
`default_nettype wire

// [hdl/sdcs_cfg.svh]
// Constants of the serial driver control and status block
`ifndef SDCS_CFG_SVH
`define SDCS_CFG_SVH
`define SDCS_WORD_W 16
`define SDCS_CHAN_N 12
`define SDCS_CTRL_RESET 16'he000
`define SDCS_BIT_CLEAR 0
`define SDCS_BIT_CHAN_LO 1
`define SDCS_BIT_CHAN_HI 12
`define SDCS_BIT_OPEN_N 13
`define SDCS_BIT_DELAY 14
`define SDCS_BIT_SOFT_INH 15
`define SDCS_BIT_WARN 0
`define SDCS_BIT_SHORT 13
`define SDCS_BIT_STANDBY 14
`define SDCS_BIT_SUPPLY 15
`define SDCS_CLK_PERIOD_NS 40
`define SDCS_T_SHORT_LONG_US 100000
`define SDCS_T_SHORT_SHORT_US 12500
`define SDCS_T_OV_LONG_US 15000
`define SDCS_T_OV_SHORT_US 3500
`define SDCS_T_UV_US 10000
`define SDCS_FIFO_DEPTH 32
`endif

// [hdl/sdcs_fifo.sv]
// Word FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sdcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid_q,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("sdcs_fifo depth must be a power of two of at least 2");

  // Words in memory only; the output register is one extra stage
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign pop = (count_q != '0) && (!out_valid_q || out_ready);

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      out_valid_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      if (pop)
        out_valid_q <= 1'b1;
      else if (out_ready)
        out_valid_q <= 1'b0;
    end

  sdcs_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data(in_data),
    .rd_en(pop),
    .rd_addr(rd_ptr_q),
    .rd_data_q(out_data)
  );
endmodule
`default_nettype wire

// [hdl/sdcs_mem.sv]
// Word memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module sdcs_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_q
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge ref_clk)
    if (clk_en && wr_en)
      mem_q[wr_addr] <= wr_data;

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
      rd_data_q <= '0;
    else if (clk_en && rd_en)
      rd_data_q <= mem_q[rd_addr];
endmodule
`default_nettype wire

// [hdl/sdcs_pkg.sv]
// Types of the serial driver control and status block
`default_nettype none
package sdcs_pkg;
  typedef enum logic [0:0] {
    SDCS_LINK_IDLE = 1'b0,
    SDCS_LINK_FRAME = 1'b1
  } sdcs_link_t;
endpackage
`default_nettype wire

// [hdl/sdcs_top.sv]
// Serial control and status logic of the twelve-channel load driver
`timescale 1ns/100ps
`default_nettype none
`include "sdcs_cfg.svh"
module sdcs_top
  import sdcs_pkg::*;
#(
  parameter int CNT_W = 22,
  parameter int SHORT_LONG_CYC = `SDCS_T_SHORT_LONG_US * 1000 / `SDCS_CLK_PERIOD_NS,
  parameter int SHORT_SHORT_CYC = `SDCS_T_SHORT_SHORT_US * 1000 / `SDCS_CLK_PERIOD_NS,
  parameter int OV_LONG_CYC = `SDCS_T_OV_LONG_US * 1000 / `SDCS_CLK_PERIOD_NS,
  parameter int OV_SHORT_CYC = `SDCS_T_OV_SHORT_US * 1000 / `SDCS_CLK_PERIOD_NS,
  parameter int UV_CYC = `SDCS_T_UV_US * 1000 / `SDCS_CLK_PERIOD_NS,
  parameter int FIFO_DEPTH = `SDCS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Serial link from the host
  input wire logic chip_select_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  // Condition inputs from the analog side
  input wire logic standby_pin_n,
  input wire logic supply_over,
  input wire logic supply_under,
  input wire logic temp_warn_set,
  input wire logic temp_warn_reset,
  input wire logic temp_shutdown,
  input wire logic [`SDCS_CHAN_N-1:0] short_detect,
  input wire logic [`SDCS_CHAN_N-1:0] open_load_detect,
  // Output stage control
  output logic [`SDCS_CHAN_N-1:0] switch_on,
  output logic [`SDCS_CHAN_N-1:0] open_load_current_en,
  output logic standby_state
);
  localparam int W = `SDCS_WORD_W;
  localparam int N = `SDCS_CHAN_N;
  localparam int CW = $clog2(W + 1);

  if (CNT_W < 2 || CNT_W > 31)
    $error("sdcs_top counter width out of range");
  if (SHORT_LONG_CYC < 1 || SHORT_LONG_CYC >= (1 << CNT_W) || SHORT_SHORT_CYC < 1)
    $error("sdcs_top short delay does not fit the counter");
  if (OV_LONG_CYC < 1 || OV_LONG_CYC >= (1 << CNT_W) || OV_SHORT_CYC < 1)
    $error("sdcs_top overvoltage delay does not fit the counter");
  if (UV_CYC < 1 || UV_CYC >= (1 << CNT_W))
    $error("sdcs_top undervoltage delay does not fit the counter");

  // Picks the long or the short delay from the delay select bit
  function automatic logic [CNT_W-1:0] pick_delay(input logic sel, input int long_cyc, input int short_cyc);
    pick_delay = sel ? CNT_W'(long_cyc) : CNT_W'(short_cyc);
  endfunction

  // Two-stage synchronisers; link stage 3 is only for edge finding
  logic [2:0] cs_sync_q;
  logic [2:0] sck_sync_q;
  logic [1:0] din_sync_q;
  logic [1:0] pin_sync_q;
  logic [1:0] over_sync_q;
  logic [1:0] under_sync_q;
  logic [1:0] wset_sync_q;
  logic [1:0] wrst_sync_q;
  logic [1:0] tsd_sync_q;
  logic [N-1:0] short_s1_q;
  logic [N-1:0] short_s2_q;
  logic [N-1:0] open_s1_q;
  logic [N-1:0] open_s2_q;

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      cs_sync_q <= 3'h7;
      sck_sync_q <= 3'h0;
      din_sync_q <= 2'h0;
      pin_sync_q <= 2'h0;
      over_sync_q <= 2'h0;
      under_sync_q <= 2'h0;
      wset_sync_q <= 2'h0;
      wrst_sync_q <= 2'h0;
      tsd_sync_q <= 2'h0;
      short_s1_q <= '0;
      short_s2_q <= '0;
      open_s1_q <= '0;
      open_s2_q <= '0;
    end
    else if (clk_en)
    begin
      cs_sync_q <= {cs_sync_q[1:0], chip_select_n};
      sck_sync_q <= {sck_sync_q[1:0], shift_clock};
      din_sync_q <= {din_sync_q[0], serial_in};
      pin_sync_q <= {pin_sync_q[0], standby_pin_n};
      over_sync_q <= {over_sync_q[0], supply_over};
      under_sync_q <= {under_sync_q[0], supply_under};
      wset_sync_q <= {wset_sync_q[0], temp_warn_set};
      wrst_sync_q <= {wrst_sync_q[0], temp_warn_reset};
      tsd_sync_q <= {tsd_sync_q[0], temp_shutdown};
      short_s1_q <= short_detect;
      short_s2_q <= short_s1_q;
      open_s1_q <= open_load_detect;
      open_s2_q <= open_s1_q;
    end

  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic sck_rise;
  logic over_s;
  logic under_s;
  assign cs_fall = cs_sync_q[2] && !cs_sync_q[1];
  assign cs_rise = !cs_sync_q[2] && cs_sync_q[1];
  assign sck_fall = sck_sync_q[2] && !sck_sync_q[1];
  assign sck_rise = !sck_sync_q[2] && sck_sync_q[1];
  assign over_s = over_sync_q[1];
  assign under_s = under_sync_q[1];

  // Control register and the state the faults keep
  logic [W-1:0] ctrl_q;
  logic clear_q;
  logic warn_q;
  logic tsd_q;
  logic supply_flag_q;
  logic supply_off_q;
  logic [N-1:0] short_off_q;
  logic [W-1:0] status;
  logic standby;
  logic outputs_blocked;

  // Link frame: shift in, shift out, hand full words to the FIFO
  sdcs_link_t link_q;
  logic [W-1:0] rx_q;
  logic [W-1:0] tx_q;
  logic [CW-1:0] bits_q;
  logic fresh_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [W-1:0] fifo_out_data;

  // A word is offered only if all sixteen bits came in
  assign fifo_in_valid = (link_q == SDCS_LINK_FRAME) && cs_rise && (bits_q >= CW'(W));

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      link_q <= SDCS_LINK_IDLE;
      rx_q <= '0;
      tx_q <= '0;
      bits_q <= '0;
      fresh_q <= 1'b0;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (link_q)
        SDCS_LINK_IDLE:
        begin
          serial_out_oe <= 1'b0;
          if (cs_fall)
          begin
            link_q <= SDCS_LINK_FRAME;
            bits_q <= '0;
            fresh_q <= 1'b0;
            tx_q <= status;
            serial_out <= status[`SDCS_BIT_WARN];
            serial_out_oe <= 1'b1;
          end
        end
        SDCS_LINK_FRAME:
        begin
          if (cs_rise)
          begin
            link_q <= SDCS_LINK_IDLE;
            serial_out_oe <= 1'b0;
          end
          else
          begin
            if (sck_fall)
            begin
              rx_q <= {din_sync_q[1], rx_q[W-1:1]};
              if (bits_q != CW'(W))
                bits_q <= bits_q + 1'b1;
              fresh_q <= 1'b1;
            end
            // No rise shifts before the first sample, so bit 0 holds until then
            if (sck_rise && fresh_q)
            begin
              tx_q <= {rx_q[W-1], tx_q[W-1:1]};
              serial_out <= tx_q[1];
              fresh_q <= 1'b0;
            end
          end
        end
      endcase
    end

  // Words queue between the link and the control register
  logic apply;
  sdcs_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rx_q),
    .out_valid_q(fifo_out_valid),
    .out_ready(!clear_q),
    .out_data(fifo_out_data)
  );
  assign apply = fifo_out_valid && !clear_q;

  // A word with the clear bit holds off the next word one cycle so the clear finishes first
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      ctrl_q <= `SDCS_CTRL_RESET;
      clear_q <= 1'b0;
    end
    else if (clk_en)
    begin
      clear_q <= 1'b0;
      if (apply)
      begin
        ctrl_q <= fifo_out_data;
        clear_q <= fifo_out_data[`SDCS_BIT_CLEAR];
      end
    end

  // Temperature prewarning and shutdown
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      warn_q <= 1'b0;
      tsd_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wset_sync_q[1])
        warn_q <= 1'b1;
      else if (wrst_sync_q[1])
        warn_q <= 1'b0;
      // Shutdown ends only once cool and cleared; a live shutdown beats the clear
      if (tsd_sync_q[1])
        tsd_q <= 1'b1;
      else if (clear_q)
        tsd_q <= 1'b0;
    end

  // Supply fault timer
  logic [CNT_W-1:0] sup_cnt_q;
  logic [CNT_W-1:0] ov_limit;
  logic sup_expired;
  assign ov_limit = pick_delay(ctrl_q[`SDCS_BIT_DELAY], OV_LONG_CYC, OV_SHORT_CYC);
  assign sup_expired = (over_s && sup_cnt_q >= ov_limit) || (under_s && sup_cnt_q >= CNT_W'(UV_CYC));

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      sup_cnt_q <= '0;
      supply_off_q <= 1'b0;
      supply_flag_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!over_s && !under_s)
      begin
        sup_cnt_q <= '0;
        supply_off_q <= 1'b0;
      end
      else if (sup_expired)
        supply_off_q <= 1'b1;
      else
        sup_cnt_q <= sup_cnt_q + 1'b1;
      if (sup_expired)
        supply_flag_q <= 1'b1;
      else if (clear_q)
        supply_flag_q <= 1'b0;
    end

  // Per-channel short timers
  logic [CNT_W-1:0] short_limit;
  assign short_limit = pick_delay(ctrl_q[`SDCS_BIT_DELAY], SHORT_LONG_CYC, SHORT_SHORT_CYC);

  for (genvar i = 0; i < N; i++)
  begin : g_short
    logic [CNT_W-1:0] cnt_q;
    logic trip;
    // A short counts only while its stage is actually driven
    assign trip = short_s2_q[i] && switch_on[i] && (warn_q || cnt_q >= short_limit);

    always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n)
      begin
        cnt_q <= '0;
        short_off_q[i] <= 1'b0;
      end
      else if (clk_en)
      begin
        if (short_s2_q[i] && switch_on[i])
          cnt_q <= (cnt_q >= short_limit) ? cnt_q : cnt_q + 1'b1;
        else
          cnt_q <= '0;
        if (trip)
          short_off_q[i] <= 1'b1;
        else if (clear_q)
          short_off_q[i] <= 1'b0;
      end
  end

  // Inhibit, output enables and status word
  logic [N-1:0] chan_req;
  logic open_check;
  assign chan_req = ctrl_q[`SDCS_BIT_CHAN_HI:`SDCS_BIT_CHAN_LO];
  assign open_check = !ctrl_q[`SDCS_BIT_OPEN_N];
  assign standby = !ctrl_q[`SDCS_BIT_SOFT_INH] || !pin_sync_q[1];
  assign outputs_blocked = standby || supply_off_q || tsd_q;

  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n)
    begin
      switch_on <= '0;
      open_load_current_en <= '0;
      standby_state <= 1'b0;
    end
    else if (clk_en)
    begin
      switch_on <= outputs_blocked ? '0 : (chan_req & ~short_off_q);
      open_load_current_en <= open_check ? ~chan_req : '0;
      standby_state <= standby;
    end

  always_comb
  begin
    status = '0;
    status[`SDCS_BIT_WARN] = warn_q;
    // A good load can only be judged while its stage is off
    status[`SDCS_BIT_CHAN_HI:`SDCS_BIT_CHAN_LO] = open_check ? (open_s2_q & ~chan_req) : switch_on;
    status[`SDCS_BIT_SHORT] = |short_off_q;
    status[`SDCS_BIT_STANDBY] = standby;
    status[`SDCS_BIT_SUPPLY] = supply_flag_q;
    if (tsd_q)
      status = '1;
  end

  // A full FIFO refuses the frame; the word is lost and the host must resend
  logic unused_ready;
  assign unused_ready = fifo_in_ready;
endmodule
`default_nettype wire
